// File: verilog/line_if_control_regs.sv
/*
  line_if_control_regs: APB register bank for the line interface controls, with the
  decoded control levels, one-shot reset and violation insertion, and the transmit
  line output stage (power-down, alarm, pattern, square wave, open drain).
  assumes: zero-wait APB master on pclk, transmit bits arrive as pos/neg marks with a
  one-cycle valid strobe, line mode set by the surrounding mode logic.
*/
//
// Notes on behaviour
// - power bit low tri-states both line outputs
// - attenuator disable bit; attenuator only T1/E1
// - depth bit: 0 deep buffer, 1 shallow
// - placement bit: 0 receive, 1 transmit path
// - equalizer limit chosen by bit and mode
// - E1 build-out codes 000,001,100,101 decoded
// - T1 codes 000-100 cable ranges, rest reserved
// - gain code sets level in fixed mode
// - gain select 0 means automatic, code ignored
// - custom driver, zero build-out: square wave
// - custom driver, nonzero build-out: open drain
// - current limiter on unless disabled or 6312
// - composite filter only in composite mode
// - attenuator clock mux used in T1 only
// - alarm bit low sends unframed all ones
// - one violation at next three-ones run, T1/E1 only
// - reset bit rising resets recovery, recenters attenuator
// - pattern bit sends alternating ones and zeros
// - monitor bits select receive gain boost
// - mark inversion enable and invert bits
`timescale 1ns/1ps

module line_if_control_regs
  import line_if_pkg::*;
(
  input  wire logic        pclk,                  // bus clock, 200 MHz
  input  wire logic        presetn,               // async reset, active low
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb direction
  input  wire logic [11:0] paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  input  wire logic [3:0]  pstrb,                 // apb byte strobes
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error on unmapped address
  input  wire line_mode_t  line_mode,             // current network mode
  input  wire logic        tx_bit_valid,          // one transmit bit this cycle
  input  wire logic        tx_pos_in,             // positive mark from encoder
  input  wire logic        tx_neg_in,             // negative mark from encoder
  output logic             tx_line_pos_o,         // positive line output level
  output logic             tx_line_pos_oe,        // positive line output enable
  output logic             tx_line_neg_o,         // negative line output level
  output logic             tx_line_neg_oe,        // negative line output enable
  output logic             jitter_atten_enable,   // attenuator in use
  output logic             jitter_buffer_short,   // 32-bit buffer selected
  output logic             jitter_atten_in_tx,    // attenuator in transmit path
  output logic             jitter_clock_from_pll, // attenuator clock from pll
  output eq_limit_t        rx_eq_limit,           // equalizer gain limit
  output logic      [2:0]  build_out_code,        // build-out selection
  output logic             build_out_high_rl,     // E1 high return loss variant
  output logic             build_out_120_ohm,     // E1 120 ohm level
  output logic             build_out_reserved,    // code reserved in this mode
  output logic             tx_auto_gain,          // transmit agc in use
  output logic      [5:0]  tx_fixed_gain,         // fixed gain, zero under agc
  output logic             current_limit_enable,  // 50 mA limiter active
  output logic             rx_composite_filter,   // 64 kHz clock filter active
  output logic      [1:0]  monitor_gain,          // receive gain boost select
  output logic             mark_inversion_en,     // cmi line coding
  output logic             mark_inversion_inv,    // cmi polarity invert
  output logic             clock_recovery_reset,  // one-cycle recovery reset
  output logic             jitter_recenter,       // one-cycle attenuator recenter
  output logic             bpv_inserted           // one-cycle, violation sent
);

  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] ctrl3_q;
  logic [7:0] gain_q;
  logic       access;
  logic       mapped;
  logic [7:0] reg_idx;
  logic       wr_en;
  logic [7:0] wbyte;
  logic       wr1;
  logic       wr2;
  logic       wr3;
  logic       wr4;
  logic       rst_rise;
  logic       bpv_rise;
  logic       rst_pulse_q;
  logic       bpv_armed_q;
  logic [1:0] ones_run_q;
  logic       last_pos_q;
  logic       pos_q;
  logic       neg_q;
  logic       alt_phase_q;
  logic       bpv_pulse_q;
  logic       mark_in;
  logic       bpv_supported;
  logic       do_bpv;
  logic       sq_wave;
  logic       open_drain;
  logic       t1_or_e1;

  // ---------------- apb slave ----------------
  assign access  = psel && penable;
  assign pready  = 1'b1;
  assign reg_idx = paddr[9:2];
  assign mapped  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00)
                && (reg_idx == IDX_LINE_IF_CONTROL_1 || reg_idx == IDX_LINE_IF_CONTROL_2
                 || reg_idx == IDX_LINE_IF_CONTROL_3
                 || reg_idx == IDX_TRANSMIT_BUILD_OUT_GAIN);
  assign pslverr = access && !mapped;
  assign wr_en   = access && pwrite && mapped && pstrb[0];
  assign wbyte   = pwdata[7:0];
  assign wr1     = wr_en && (reg_idx == IDX_LINE_IF_CONTROL_1);
  assign wr2     = wr_en && (reg_idx == IDX_LINE_IF_CONTROL_2);
  assign wr3     = wr_en && (reg_idx == IDX_LINE_IF_CONTROL_3);
  assign wr4     = wr_en && (reg_idx == IDX_TRANSMIT_BUILD_OUT_GAIN);

  always_comb
  begin
    prdata = 32'h0000_0000;
    if (access && !pwrite && mapped)
    begin
      unique case (reg_idx)
        IDX_LINE_IF_CONTROL_1: prdata[7:0] = ctrl1_q;
        IDX_LINE_IF_CONTROL_2: prdata[7:0] = ctrl2_q;
        IDX_LINE_IF_CONTROL_3: prdata[7:0] = ctrl3_q;
        default:               prdata[7:0] = gain_q;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl1_q <= RST_LINE_IF_CONTROL_1;
      ctrl2_q <= RST_LINE_IF_CONTROL_2;
      ctrl3_q <= RST_LINE_IF_CONTROL_3;
      gain_q  <= RST_TRANSMIT_BUILD_OUT_GAIN;
    end
    else
    begin
      if (wr1)
        ctrl1_q <= wbyte & MASK_LINE_IF_CONTROL_1;
      if (wr2)
        ctrl2_q <= wbyte & MASK_LINE_IF_CONTROL_2;
      if (wr3)
        ctrl3_q <= wbyte & MASK_LINE_IF_CONTROL_3;
      if (wr4)
        gain_q <= wbyte & MASK_TRANSMIT_BUILD_OUT_GAIN;
    end
  end

  // ---------------- decoded controls ----------------
  assign t1_or_e1              = (line_mode == MODE_T1) || (line_mode == MODE_E1);
  assign jitter_atten_enable   = !ctrl1_q[BIT_JITTER_ATTEN_DISABLE] && t1_or_e1;
  assign jitter_buffer_short   = ctrl1_q[BIT_JITTER_BUFFER_DEPTH];
  assign jitter_atten_in_tx    = ctrl1_q[BIT_JITTER_ATTEN_PLACEMENT];
  assign jitter_clock_from_pll = ctrl2_q[BIT_JITTER_CLOCK_MUX]
                              && (line_mode == MODE_T1);
  assign build_out_code        = ctrl1_q[POS_BUILD_OUT +: 3];

  always_comb
  begin
    if (line_mode == MODE_E1)
      rx_eq_limit = ctrl1_q[BIT_RX_EQ_GAIN_LIMIT] ? EQ_E1_SHORT_12DB
                                                  : EQ_E1_LONG_43DB;
    else
      rx_eq_limit = ctrl1_q[BIT_RX_EQ_GAIN_LIMIT] ? EQ_T1_LIMITED_15DB
                                                  : EQ_T1_LONG_36DB;
  end

  // E1 decodes four codes, T1 five ranges; anything else is flagged reserved
  always_comb
  begin
    build_out_high_rl  = 1'b0;
    build_out_120_ohm  = 1'b0;
    build_out_reserved = 1'b0;
    if (line_mode == MODE_E1)
    begin
      build_out_high_rl  = (build_out_code == BO_E1_75_HIGH_RL)
                        || (build_out_code == BO_E1_120_HIGH_RL);
      build_out_120_ohm  = (build_out_code == BO_E1_120_NORMAL)
                        || (build_out_code == BO_E1_120_HIGH_RL);
      build_out_reserved = !(build_out_code == BO_E1_75_NORMAL || build_out_120_ohm
                          || build_out_code == BO_E1_75_HIGH_RL);
    end
    else if (line_mode == MODE_T1)
      build_out_reserved = (build_out_code > BO_T1_LAST_RANGE);
  end

  assign tx_auto_gain         = !gain_q[BIT_AUTO_GAIN_SELECT];
  assign tx_fixed_gain        = tx_auto_gain ? 6'h00
                              : gain_q[POS_TX_GAIN_CODE +: 6];
  assign current_limit_enable = !ctrl2_q[BIT_SHORT_LIMIT_DISABLE]
                             && (line_mode != MODE_6312K);
  assign rx_composite_filter  = ctrl2_q[BIT_RX_COMPOSITE_FILTER_EN]
                             && (line_mode == MODE_COMPOSITE);
  assign monitor_gain         = {ctrl3_q[BIT_MONITOR_GAIN_HI],
                                 ctrl3_q[BIT_MONITOR_GAIN_LO]};
  assign mark_inversion_en    = ctrl3_q[BIT_MARK_INVERSION_ENABLE];
  assign mark_inversion_inv   = ctrl3_q[BIT_MARK_INVERSION_INVERT];

  // ---------------- one-shot actions ----------------
  // new value compared against the held one, so rewriting a 1 does nothing
  assign rst_rise = wr2 && wbyte[BIT_LINE_IF_RESET] && !ctrl2_q[BIT_LINE_IF_RESET];
  assign bpv_rise = wr2 && wbyte[BIT_INSERT_BIPOLAR_VIOL]
                 && !ctrl2_q[BIT_INSERT_BIPOLAR_VIOL];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_pulse_q <= 1'b0;
    else
      rst_pulse_q <= rst_rise;
  end

  assign clock_recovery_reset = rst_pulse_q;
  assign jitter_recenter      = rst_pulse_q;

  // ---------------- transmit line stage ----------------
  assign bpv_supported = (line_mode != MODE_COMPOSITE) && (line_mode != MODE_6312K);
  assign mark_in       = tx_pos_in || tx_neg_in;
  assign do_bpv        = tx_bit_valid && bpv_armed_q && mark_in
                      && (ones_run_q == BPV_RUN_BEFORE);
  assign sq_wave       = ctrl2_q[BIT_CUSTOM_DRIVER_SELECT] && (build_out_code == 3'b000);
  assign open_drain    = ctrl2_q[BIT_CUSTOM_DRIVER_SELECT] && (build_out_code != 3'b000);

  // armed by a rising write, spent by one insertion; a new rise wins the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bpv_armed_q <= 1'b0;
    else if (bpv_rise && bpv_supported)
      bpv_armed_q <= 1'b1;
    else if (do_bpv || !bpv_supported)
      bpv_armed_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ones_run_q <= 2'd0;
    else if (tx_bit_valid)
    begin
      if (!mark_in || do_bpv)
        ones_run_q <= 2'd0;
      else if (ones_run_q != BPV_RUN_BEFORE)
        ones_run_q <= ones_run_q + 2'd1;
    end
  end

  // line symbols: pattern, alarm, square wave, violation, then normal data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q       <= 1'b0;
      neg_q       <= 1'b0;
      last_pos_q  <= 1'b0;
      alt_phase_q <= 1'b0;
      bpv_pulse_q <= 1'b0;
    end
    else
    begin
      bpv_pulse_q <= do_bpv && ctrl2_q[BIT_TX_ALARM_ALL_ONES_N]
                  && !ctrl3_q[BIT_TX_ALTERNATING_PATTERN] && !sq_wave;
      if (tx_bit_valid)
      begin
        alt_phase_q <= !alt_phase_q;
        if (ctrl3_q[BIT_TX_ALTERNATING_PATTERN])
        begin
          // mark on every other bit, marks alternate in polarity
          pos_q <= alt_phase_q && !last_pos_q;
          neg_q <= alt_phase_q && last_pos_q;
          if (alt_phase_q)
            last_pos_q <= !last_pos_q;
        end
        else if (!ctrl2_q[BIT_TX_ALARM_ALL_ONES_N])
        begin
          pos_q      <= !last_pos_q;
          neg_q      <= last_pos_q;
          last_pos_q <= !last_pos_q;
        end
        else if (sq_wave)
        begin
          pos_q <= alt_phase_q;
          neg_q <= !alt_phase_q;
        end
        else if (do_bpv)
        begin
          // repeat the last polarity to break the alternation
          pos_q <= last_pos_q;
          neg_q <= !last_pos_q;
        end
        else
        begin
          pos_q <= tx_pos_in;
          neg_q <= tx_neg_in;
          if (mark_in)
            last_pos_q <= tx_pos_in;
        end
      end
    end
  end

  assign bpv_inserted = bpv_pulse_q;

  // open drain pulls low during a mark and floats otherwise
  always_comb
  begin
    tx_line_pos_o  = 1'b0;
    tx_line_neg_o  = 1'b0;
    tx_line_pos_oe = 1'b0;
    tx_line_neg_oe = 1'b0;
    if (ctrl1_q[BIT_TX_POWER_ON])
    begin
      if (open_drain)
      begin
        tx_line_pos_oe = pos_q;
        tx_line_neg_oe = neg_q;
      end
      else
      begin
        tx_line_pos_o  = pos_q;
        tx_line_neg_o  = neg_q;
        tx_line_pos_oe = 1'b1;
        tx_line_neg_oe = 1'b1;
      end
    end
  end

  // ---------------- assertions ----------------
  sequence s_wr_ctrl1;
    psel && penable && pwrite && pstrb[0] && paddr == {2'b00, IDX_LINE_IF_CONTROL_1, 2'b00};
  endsequence

  sequence s_wr_ctrl2_rise(int b);
    psel && penable && pwrite && pstrb[0] && paddr == {2'b00, IDX_LINE_IF_CONTROL_2, 2'b00}
      && pwdata[b] && !ctrl2_q[b];
  endsequence

  AST_TX_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_ctrl1 and !pwdata[0]) |=> (!tx_line_pos_oe && !tx_line_neg_oe))
    else $error("line outputs driven after power-down write");

  AST_JA_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (s_wr_ctrl1 and line_mode == MODE_T1) ##1 (line_mode == MODE_T1)
      |-> jitter_atten_enable == !$past(pwdata[1]))
    else $error("attenuator enable does not follow disable bit");

  AST_JA_DEPTH: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_ctrl1 |=> jitter_buffer_short == $past(pwdata[2]))
    else $error("buffer depth does not follow written bit");

  AST_RESET_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
    s_wr_ctrl2_rise(BIT_LINE_IF_RESET) |=> clock_recovery_reset && jitter_recenter
      ##1 !clock_recovery_reset)
    else $error("line reset pulse missing or too long");

  AST_BPV_SPENT: assert property (@(posedge pclk) disable iff (!presetn)
    (do_bpv && !bpv_rise) |=> !bpv_armed_q ##1 !do_bpv)
    else $error("violation not spent after insertion");

  AST_BPV_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
    bpv_inserted |-> (pos_q == $past(last_pos_q)) && (neg_q != pos_q))
    else $error("violation not sent with repeated polarity");

  AST_ALL_ONES: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_bit_valid && !ctrl2_q[BIT_TX_ALARM_ALL_ONES_N] && !ctrl3_q[0])
      |=> (pos_q ^ neg_q))
    else $error("alarm does not send a mark every bit");

  AST_GAIN_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pstrb[0]
      && paddr == {2'b00, IDX_TRANSMIT_BUILD_OUT_GAIN, 2'b00})
      |=> tx_auto_gain == !$past(pwdata[6])
       && tx_fixed_gain == ($past(pwdata[6]) ? $past(pwdata[5:0]) : 6'h00))
    else $error("gain outputs do not follow written gain register");

  AST_CC_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
    rx_composite_filter |-> line_mode == MODE_COMPOSITE)
    else $error("composite filter active outside composite mode");

  AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule // line_if_control_regs

// File: pkg/line_if_pkg.sv
/*
  line_if_pkg: register indices, field positions, reset values and line modes of the
  line interface control register bank.
  assumes: byte address of a register is four times its index, 32-bit APB data.
*/
package line_if_pkg;

  // register indices; byte address is index * 4
  localparam logic [7:0] IDX_LINE_IF_CONTROL_1       = 8'h30;
  localparam logic [7:0] IDX_LINE_IF_CONTROL_2       = 8'h31;
  localparam logic [7:0] IDX_LINE_IF_CONTROL_3       = 8'h32;
  localparam logic [7:0] IDX_TRANSMIT_BUILD_OUT_GAIN = 8'h34;

  // reset values
  localparam logic [7:0] RST_LINE_IF_CONTROL_1       = 8'h00;
  localparam logic [7:0] RST_LINE_IF_CONTROL_2       = 8'h00;
  localparam logic [7:0] RST_LINE_IF_CONTROL_3       = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_BUILD_OUT_GAIN = 8'h00;

  // implemented bits; the rest store nothing and read as zero
  localparam logic [7:0] MASK_LINE_IF_CONTROL_1       = 8'hFF;
  localparam logic [7:0] MASK_LINE_IF_CONTROL_2       = 8'h7F;
  localparam logic [7:0] MASK_LINE_IF_CONTROL_3       = 8'hD9;
  localparam logic [7:0] MASK_TRANSMIT_BUILD_OUT_GAIN = 8'h7F;

  // line_if_control_1 fields
  localparam int BIT_TX_POWER_ON            = 0;
  localparam int BIT_JITTER_ATTEN_DISABLE   = 1;
  localparam int BIT_JITTER_BUFFER_DEPTH    = 2;
  localparam int BIT_JITTER_ATTEN_PLACEMENT = 3;
  localparam int BIT_RX_EQ_GAIN_LIMIT       = 4;
  localparam int POS_BUILD_OUT              = 5;  // build_out_bit0..2 at 5..7

  // line_if_control_2 fields
  localparam int BIT_CUSTOM_DRIVER_SELECT   = 0;
  localparam int BIT_SHORT_LIMIT_DISABLE    = 1;
  localparam int BIT_RX_COMPOSITE_FILTER_EN = 2;
  localparam int BIT_JITTER_CLOCK_MUX       = 3;
  localparam int BIT_TX_ALARM_ALL_ONES_N    = 4;
  localparam int BIT_INSERT_BIPOLAR_VIOL    = 5;
  localparam int BIT_LINE_IF_RESET         = 6;

  // line_if_control_3 fields
  localparam int BIT_TX_ALTERNATING_PATTERN = 0;
  localparam int BIT_MONITOR_GAIN_LO        = 3;
  localparam int BIT_MONITOR_GAIN_HI        = 4;
  localparam int BIT_MARK_INVERSION_INVERT  = 6;
  localparam int BIT_MARK_INVERSION_ENABLE  = 7;

  // transmit_build_out_gain fields
  localparam int POS_TX_GAIN_CODE           = 0;  // tx_gain_code at 0..5
  localparam int BIT_AUTO_GAIN_SELECT       = 6;

  // build-out codes
  localparam logic [2:0] BO_E1_75_NORMAL   = 3'b000;
  localparam logic [2:0] BO_E1_120_NORMAL  = 3'b001;
  localparam logic [2:0] BO_E1_75_HIGH_RL  = 3'b100;
  localparam logic [2:0] BO_E1_120_HIGH_RL = 3'b101;
  localparam logic [2:0] BO_T1_LAST_RANGE  = 3'b100;

  // consecutive marks before a violation may be inserted
  localparam logic [1:0] BPV_RUN_BEFORE = 2'd2;

  typedef enum logic [1:0] {
    MODE_T1,
    MODE_E1,
    MODE_COMPOSITE,
    MODE_6312K
  } line_mode_t;

  typedef enum logic [2:0] {
    EQ_T1_LONG_36DB,
    EQ_T1_LIMITED_15DB,
    EQ_E1_LONG_43DB,
    EQ_E1_SHORT_12DB
  } eq_limit_t;

endpackage

// File: bench/line_encoder_model.sv
/*
  line_encoder_model: stand-in for the transmit encoder that feeds marks to the line stage.
  assumes: one bit each pclk cycle while enabled, sent as marks of alternating polarity.
*/
`timescale 1ns/1ps

module line_encoder_model
(
  input  wire logic pclk,         // bus clock
  input  wire logic presetn,      // async reset, active low
  input  wire logic en,           // send bits
  output logic      tx_bit_valid, // one bit this cycle
  output logic      tx_pos_in,    // positive mark
  output logic      tx_neg_in     // negative mark
);
  logic pol_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pol_q        <= 1'b0;
      tx_bit_valid <= 1'b0;
      tx_pos_in    <= 1'b0;
      tx_neg_in    <= 1'b0;
    end
    else
    begin
      pol_q        <= en ? ~pol_q : pol_q;
      tx_bit_valid <= en;
      tx_pos_in    <= en & ~pol_q;
      tx_neg_in    <= en & pol_q;
    end
  end
endmodule // line_encoder_model

// File: bench/test_line_if_control_regs.sv
/*
  test_line_if_control_regs: APB read and write sequences with expected values.
  assumes: APB slave answering through pready, encoder model on the transmit inputs.
*/
`timescale 1ns/1ps

module test_line_if_control_regs import line_if_pkg::*;;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, en = 0;
  logic [11:0] paddr = 12'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, err, tv, tp, tn, po, poe, no, noe, crr, hrl, rsv, agc, bpv;
  logic [5:0]  fg;
  logic [2:0]  bo3;
  logic [1:0]  mg;
  logic        jae, jbs, jit, jcp, b120, cle, rcf, mie, mii, jrc;
  eq_limit_t   eql;
  line_mode_t  mode = MODE_T1;
  logic [11:0] adr [4] = '{12'h00C0, 12'h00C4, 12'h00C8, 12'h00D0};
  logic [7:0]  msk [4] = '{8'hFF, 8'h7F, 8'hD9, 8'h7F};
  int          errors = 0, total_checks = 0, rcnt = 0, bcnt = 0, m;

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) rcnt += (crr === 1'b1);
  always @(posedge pclk) bcnt += (bpv === 1'b1);

  line_encoder_model enc (.pclk(pclk), .presetn(presetn), .en(en), .tx_bit_valid(tv),
    .tx_pos_in(tp), .tx_neg_in(tn));
  line_if_control_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_mode(mode), .tx_bit_valid(tv),
    .tx_pos_in(tp), .tx_neg_in(tn), .tx_line_pos_o(po), .tx_line_pos_oe(poe),
    .tx_line_neg_o(no), .tx_line_neg_oe(noe), .jitter_atten_enable(jae),
    .jitter_buffer_short(jbs), .jitter_atten_in_tx(jit), .jitter_clock_from_pll(jcp),
    .rx_eq_limit(eql), .build_out_code(bo3), .build_out_high_rl(hrl),
    .build_out_120_ohm(b120), .build_out_reserved(rsv), .tx_auto_gain(agc),
    .tx_fixed_gain(fg), .current_limit_enable(cle), .rx_composite_filter(rcf),
    .monitor_gain(mg), .mark_inversion_en(mie), .mark_inversion_inv(mii),
    .clock_recovery_reset(crr), .jitter_recenter(jrc), .bpv_inserted(bpv));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic setm(input line_mode_t v);
    @(posedge pclk);
    mode <= v;
    #1;
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #100000;
    errors++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk("oe", 0, {poe, noe});
    chk("agc", 1, agc);
    for (int i = 0; i < 4; i++)
    begin
      apb(0, adr[i], 8'h00);
      chk("reset value", 0, rd);
      apb(1, adr[i], msk[i]);
      apb(0, adr[i], 8'h00);
      chk("readback", {24'h00_0000, msk[i]}, rd);
    end
    chk("reset pulse", 1, rcnt);
    chk("ja enable", 0, jae);
    chk("ja depth", 1, jbs);
    chk("ja place", 1, jit);
    chk("ja clock", 1, jcp);
    chk("limiter", 0, cle);
    chk("cc filter off", 0, rcf);
    chk("monitor", 3, mg);
    chk("cmi", 3, {mie, mii});
    apb(1, adr[1], 8'h40);
    chk("held reset", 1, rcnt);
    apb(1, adr[1], 8'h00);
    apb(1, adr[1], 8'h40);
    chk("reset pulse now", 3, {crr, jrc});
    @(posedge pclk);
    #1;
    chk("pulse length", 0, crr);
    chk("second reset", 2, rcnt);
    apb(0, 12'h00CC, 8'h00);
    chk("unmapped", 1, err);
    apb(1, adr[0], 8'h10);
    chk("eq t1", EQ_T1_LIMITED_15DB, eql);
    setm(MODE_E1);
    chk("eq e1", EQ_E1_SHORT_12DB, eql);
    for (m = 0; m < 6; m++)
    begin
      apb(1, adr[0], {m[2:0], 5'h00});
      if (m != 2 && m != 3)
      begin
        chk("high rl", m / 4, hrl);
        chk("120 ohm", m % 2, b120);
      end
    end
    chk("eq e1 long", EQ_E1_LONG_43DB, eql);
    setm(MODE_T1);
    for (m = 0; m < 8; m++)
    begin
      apb(1, adr[0], {m[2:0], 5'h00});
      chk("reserved", m > 4, rsv);
      chk("code", m, bo3);
    end
    apb(1, adr[3], 8'h55);
    chk("gain", {1'b0, 6'h15}, {agc, fg});
    apb(1, adr[3], 8'h15);
    chk("auto gain", {1'b1, 6'h00}, {agc, fg});
    en <= 1'b1;
    apb(1, adr[1], 8'h10);
    apb(1, adr[2], 8'h00);
    apb(1, adr[0], 8'h01);
    repeat (3) @(posedge pclk);
    #1;
    chk("driving", 1, poe | noe);
    apb(1, adr[2], 8'h01);
    @(posedge pclk);
    m = 0;
    repeat (8) @(posedge pclk) m += (po | no);
    chk("pattern marks", 4, m);
    apb(1, adr[2], 8'h00);
    apb(1, adr[1], 8'h30);
    repeat (20) @(posedge pclk);
    chk("violation", 1, bcnt);
    apb(1, adr[1], 8'h30);
    repeat (20) @(posedge pclk);
    chk("held violation", 1, bcnt);
    apb(1, adr[1], 8'h11);
    repeat (2) @(posedge pclk);
    #1;
    chk("square", 1, po ^ no);
    m = po;
    @(posedge pclk);
    #1;
    chk("square toggle", !m, po);
    apb(1, adr[0], 8'h21);
    @(posedge pclk);
    #1;
    chk("open drain", 1, {po, no, poe ^ noe});
    apb(1, adr[1], 8'h10);
    setm(MODE_COMPOSITE);
    apb(1, adr[1], 8'h30);
    repeat (20) @(posedge pclk);
    chk("composite violation", 1, bcnt);
    apb(1, adr[1], 8'h14);
    chk("cc filter", 1, rcf);
    chk("ja off in cc", 0, jae);
    chk("limiter on", 1, cle);
    setm(MODE_6312K);
    chk("limiter 6312", 0, cle);
    apb(1, adr[0], 8'h00);
    chk("power down", 0, {poe, noe});
    conclude();
  end
endmodule // test_line_if_control_regs
